/* frp_pkg.sv */
// Purpose: shared constants, types and code table for the 100M receive/transmit coding block
// Assumes: system clock of 20 MHz; one code bit per accepted symbol
// Notes: code groups are held with the first bit on the line in bit 4
package frp_pkg;
	// clock rate and descrambler watchdog window
	localparam int CLK_MHZ = 20;
	localparam int WIN_US = 40;
	localparam int WIN_CYC = WIN_US * CLK_MHZ;
	localparam logic [9:0] WIN_LAST = 10'(WIN_CYC - 1);
	// run lengths used by lock, idle and delimiter search
	localparam logic [4:0] LOCK_RUN = 5'h1E;
	localparam logic [3:0] IDLE_RUN = 4'hA;
	localparam logic [3:0] SSD_LEAD = 4'h7;
	localparam logic [2:0] SSD_REST = 3'h7;
	// receive buffer
	localparam int FIFO_DEPTH = 32;
	localparam logic [5:0] FIFO_ROOM = 6'h1D;
	// low six bits of the scrambler seed, upper five bits are the port address
	localparam logic [5:0] SEED_LOW = 6'h01;
	// special code groups and nibbles
	localparam logic [4:0] G_IDLE = 5'h1F;
	localparam logic [4:0] G_J = 5'h18;
	localparam logic [4:0] G_K = 5'h11;
	localparam logic [4:0] G_T = 5'h0D;
	localparam logic [4:0] G_R = 5'h07;
	localparam logic [3:0] NIB_SSD = 4'h5;
	localparam logic [3:0] NIB_BAD_SSD = 4'hE;

	typedef enum logic [1:0] {LVL_ZERO, LVL_POS, LVL_NEG} frp_lvl_t;

	typedef struct packed {
		logic dv;
		logic er;
		logic [3:0] d;
	} frp_mii_t;

	// bit 4 set when the group is one of the sixteen data groups
	function automatic logic [4:0] frp_dec(input logic [4:0] g);
		case (g)
			5'h1E: return 5'h10;
			5'h09: return 5'h11;
			5'h14: return 5'h12;
			5'h15: return 5'h13;
			5'h0A: return 5'h14;
			5'h0B: return 5'h15;
			5'h0E: return 5'h16;
			5'h0F: return 5'h17;
			5'h12: return 5'h18;
			5'h13: return 5'h19;
			5'h16: return 5'h1A;
			5'h17: return 5'h1B;
			5'h1A: return 5'h1C;
			5'h1B: return 5'h1D;
			5'h1C: return 5'h1E;
			5'h1D: return 5'h1F;
			default: return 5'h00;
		endcase
	endfunction
endpackage

/* frp_pcs.sv */
// Purpose: 100M coding path: tx serialise/NRZI/MLT-3, rx MLT-3/descramble/align/decode to MII
// Assumes: symbols arrive as level strobes in the system clock domain
// Notes: the MII clock is a divided strobe, so one clock edge stands for one symbol slot
`timescale 1ns/1ns
`default_nettype none

module frp_fifo #(parameter int W = 6, parameter int DEPTH = 32) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// fill side
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [W-1:0] i_data,
	// drain side
	output logic o_valid,
	input wire logic i_ready,
	output logic [W-1:0] o_data,
	output logic [$clog2(DEPTH):0] o_count
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} frp_fifo_st_t;
	frp_fifo_st_t s, n;
	logic [W-1:0] mem [DEPTH];
	logic push, pop;

	// flags come from the count alone, so full and empty are exact
	assign o_ready = (s.cnt != (AW+1)'(DEPTH));
	assign o_valid = (s.cnt != '0);
	assign o_data = mem[s.rp];
	assign o_count = s.cnt;

	// pointer and count update
	always_comb begin
		n = s;
		push = i_valid && o_ready;
		pop = o_valid && i_ready;
		if (push) n.wp = s.wp + 1'h1;
		if (pop) n.rp = s.rp + 1'h1;
		n.cnt = s.cnt + {{AW{1'h0}}, push} - {{AW{1'h0}}, pop};
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) s <= '0;
		else s <= n;
	end

	// storage, no reset needed
	always_ff @(posedge i_clk) begin
		if (push) mem[s.wp] <= i_data;
	end
endmodule // frp_fifo

// Notes on behaviour
// - serialise tx groups into continuous NRZI stream
// - MLT-3 steps on one, holds on zero
// - rx level change becomes code bit one
// - lock key during idle, then deserialise groups
// - no idle within 40us: abort, relock
// - bypass input skips the descrambler
// - J then K sets group boundary
// - map groups to nibbles, SSD as 0101 0101
// - RX_DV with first SSD nibble onward
// - T R or two idles end frame
// - link fail or no signal drops RX_DV
// - decode bypass in MII mode puts fifth bit on error pin
// - bad group in frame raises RX_ER
// - bad SSD: RX_ER, RXD 1110, no DV
// - RXD changes on falling RX_CLK
// - RX_CLK from recovered or reference tick
// - invalid groups during RX_DV raise error
// - scrambler seed from port address
module frp_pcs
	import frp_pkg::*;
(
	// clock and reset
	input wire logic I_CLK_SYS,
	input wire logic I_RESET_N,
	// transmit groups from the encoder
	input wire logic [4:0] I_TX_GROUP,
	input wire logic I_TX_VALID,
	output logic O_TX_READY,
	// transmit line
	output logic O_TX_NRZI,
	output frp_lvl_t O_TX_MLT3,
	// received levels from clock recovery
	input wire frp_lvl_t I_RX_LEVEL,
	input wire logic I_RX_VALID,
	output logic O_RX_SYM_READY,
	// clock sources for the MII receive clock
	input wire logic I_REC_TICK,
	input wire logic I_REFERENCE_CLOCK_INPUT_TICK,
	// status pins and configuration
	input wire logic I_SIGNAL_PRESENT_FLAG,
	input wire logic I_LINK_FAIL,
	input wire logic [4:0] I_MGMT_PORT_ADDRESS,
	input wire logic I_DESCR_BYPASS,
	input wire logic I_DECODE_ENABLE,
	input wire logic I_MII_MODE,
	// MII receive side
	output logic O_RX_CLK,
	output logic [3:0] O_RXD,
	output logic O_RX_DV,
	output logic O_ERROR_OR_FIFTH_RX_BIT,
	output logic O_CRS
);
	typedef struct packed {
		logic sp1, sp2, lf1, lf2;
		logic [4:0] ad1, ad2;
		logic [1:0] boot;
		logic [10:0] scr;
		logic [4:0] grp;
		logic [2:0] idx;
		logic rdy, nrzi;
		logic [1:0] ph;
		frp_lvl_t lvl, prev;
		logic [10:0] key;
		logic locked;
		logic [4:0] run;
		logic [3:0] ones;
		logic [9:0] win;
		logic [9:0] sh;
		logic hunt;
		logic [2:0] cnt, bitc;
		logic frame, crs, saw_t, saw_i, pend, wr, sym_rdy, rxclk;
		frp_mii_t wdata, out;
	} frp_st_t;
	frp_st_t s, n;
	logic tx_sb, cb, db, rfb, fin, ok, tick, pop, f_valid, f_ready;
	logic [4:0] g, dec;
	logic [5:0] f_cnt;
	frp_mii_t f_data;

	// nibble buffer between decoder and MII; the line cannot stall,
	// so symbol intake is held off while the buffer is nearly full
	frp_fifo #(.W($bits(frp_mii_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_clk(I_CLK_SYS),
		.i_rst_n(I_RESET_N),
		.i_valid(s.wr),
		.o_ready(f_ready),
		.i_data(s.wdata),
		.o_valid(f_valid),
		.i_ready(pop),
		.o_data(f_data),
		.o_count(f_cnt)
	);

	// all next-state logic
	always_comb begin
		n = s;
		// pin synchronisers
		n.sp1 = I_SIGNAL_PRESENT_FLAG;
		n.sp2 = s.sp1;
		n.lf1 = I_LINK_FAIL;
		n.lf2 = s.lf1;
		n.ad1 = I_MGMT_PORT_ADDRESS;
		n.ad2 = s.ad1;
		ok = s.sp2 && !s.lf2;
		// one scrambled code bit per clock, idle when no group
		tx_sb = s.grp[4] ^ s.scr[10] ^ s.scr[8];
		n.scr = {s.scr[9:0], s.scr[10] ^ s.scr[8]};
		// seed taken once the address has passed the synchroniser
		if (s.boot != 2'h3) begin
			n.boot = s.boot + 2'h1;
			n.scr = {s.ad2, SEED_LOW};
		end
		n.nrzi = s.nrzi ^ tx_sb;
		// step the level only on a one
		if (tx_sb) n.ph = s.ph + 2'h1;
		// phase 0,1,2,3 gives zero, plus, zero, minus
		n.lvl = n.ph[0] ? (n.ph[1] ? LVL_NEG : LVL_POS) : LVL_ZERO;
		n.grp = {s.grp[3:0], 1'h0};
		n.idx = s.idx + 3'h1;
		n.rdy = (s.idx == 3'h3);
		if (s.idx == 3'h4) begin
			n.idx = '0;
			n.grp = I_TX_VALID ? I_TX_GROUP : G_IDLE;
		end
		// receive defaults
		cb = 1'h0;
		db = 1'h0;
		fin = 1'h0;
		g = '0;
		dec = '0;
		rfb = s.key[10] ^ s.key[8];
		n.wr = 1'h0;
		// second SSD nibble one cycle after the first
		if (s.pend) begin
			n.wr = 1'h1;
			n.wdata = '{dv: 1'h1, er: 1'h0, d: NIB_SSD};
			n.pend = 1'h0;
		end
		if (I_RX_VALID && s.sym_rdy) begin
			// a level change is a one
			cb = (I_RX_LEVEL != s.prev);
			n.prev = I_RX_LEVEL;
			db = I_DESCR_BYPASS ? cb : cb ^ rfb;
			if (s.locked) n.key = {s.key[9:0], rfb};
			else begin
				// idle is all ones, so the line bit gives the key
				n.key = {s.key[9:0], ~cb};
				n.run = (cb ^ rfb) ? s.run + 5'h01 : '0;
				n.locked = (cb ^ rfb) && (s.run == LOCK_RUN - 5'h01);
			end
			n.sh = {s.sh[8:0], db};
			n.ones = db ? ((s.ones == IDLE_RUN) ? s.ones : s.ones + 4'h1) : '0;
			g = {s.sh[3:0], db};
			dec = frp_dec(g);
			if (s.frame) begin
				n.bitc = s.bitc + 3'h1;
				if (s.bitc == 3'h4) begin
					n.bitc = '0;
					n.saw_t = 1'h0;
					n.saw_i = 1'h0;
					// delimiters end the frame and write nothing
					if (s.saw_t && g == G_R) fin = 1'h1;
					else if (s.saw_i && g == G_IDLE) fin = 1'h1;
					else if (!s.saw_t && !s.saw_i && g == G_T) n.saw_t = 1'h1;
					else if (!s.saw_t && !s.saw_i && g == G_IDLE) n.saw_i = 1'h1;
					else begin
						n.wr = 1'h1;
						// anything but data flags an error
						n.wdata = '{dv: 1'h1, er: !dec[4] || s.saw_t || s.saw_i, d: dec[3:0]};
						// raw group, fifth bit on the error pin
						if (I_MII_MODE && !I_DECODE_ENABLE) n.wdata = '{dv: 1'h1, er: g[4], d: g[3:0]};
					end
				end
			end else if (s.locked || I_DESCR_BYPASS) begin
				if (s.hunt) begin
					n.cnt = s.cnt - 3'h1;
					if (s.cnt == 3'h1) begin
						n.hunt = 1'h0;
						n.wr = 1'h1;
						// boundary fixed at the end of K
						if ({s.sh[8:0], db} == {G_J, G_K}) begin
							n.frame = 1'h1;
							n.crs = 1'h1;
							n.bitc = '0;
							n.pend = 1'h1;
							n.wdata = '{dv: 1'h1, er: 1'h0, d: NIB_SSD};
						end else begin
							n.wdata = '{dv: 1'h0, er: 1'h1, d: NIB_BAD_SSD};
						end
					end
				// the first zero of J is its third bit
				end else if (!db && s.ones >= SSD_LEAD) begin
					n.hunt = 1'h1;
					n.cnt = SSD_REST;
				end
			end
		end
		if (fin) begin
			n.frame = 1'h0;
			n.crs = 1'h0;
		end
		// watchdog, restarted by every run of idle
		if (!s.locked || s.ones == IDLE_RUN) n.win = '0;
		else if (s.win == WIN_LAST) begin
			n.win = '0;
			n.locked = 1'h0;
			n.run = '0;
			n.frame = 1'h0;
			n.crs = 1'h0;
			n.hunt = 1'h0;
		end else n.win = s.win + 10'h001;
		// lost signal or link aborts and relocks
		if (!ok) begin
			n.locked = 1'h0;
			n.frame = 1'h0;
			n.crs = 1'h0;
			n.hunt = 1'h0;
		end
		// margin of three covers the one-cycle lag of this flag
		n.sym_rdy = f_ready && (f_cnt < FIFO_ROOM);
		tick = s.sp2 ? I_REC_TICK : I_REFERENCE_CLOCK_INPUT_TICK;
		pop = 1'h0;
		if (tick) begin
			n.rxclk = ~s.rxclk;
			// data moves only as the clock falls
			if (s.rxclk) begin
				pop = 1'h1;
				n.out = f_valid ? f_data : '0;
				// valid drops at the next fall, keeping MII timing intact
				if (!ok) n.out.dv = 1'h0;
			end
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) s <= '0;
		else s <= n;
	end

	// outputs straight from state
	assign O_TX_READY = s.rdy;
	assign O_TX_NRZI = s.nrzi;
	assign O_TX_MLT3 = s.lvl;
	assign O_RX_SYM_READY = s.sym_rdy;
	assign O_RX_CLK = s.rxclk;
	assign O_RXD = s.out.d;
	assign O_RX_DV = s.out.dv;
	assign O_ERROR_OR_FIFTH_RX_BIT = s.out.er;
	assign O_CRS = s.crs;

	default clocking clk_c @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RESET_N);

	sequence ssd_nib_s;
		s.wr && s.wdata.dv && s.wdata.d == NIB_SSD;
	endsequence

	mlt_step_a: assert property ($changed(s.lvl) |-> $past(tx_sb))
		else $error("level moved without a one");
	mlt_order_a: assert property (s.lvl == LVL_POS |=> s.lvl != LVL_NEG)
		else $error("level skipped zero");
	tx_slot_a: assert property (s.rdy |=> !s.rdy [*4] ##1 s.rdy)
		else $error("group slot not five cycles");
	nrzi_bit_a: assert property ((s.nrzi ^ $past(s.nrzi)) == $past(tx_sb))
		else $error("nrzi does not follow bit");
	win_abort_a: assert property (s.locked && s.win == WIN_LAST && s.ones != IDLE_RUN
		|=> !s.locked)
		else $error("watchdog did not drop lock");
	dv_drop_a: assert property (!ok |=> !s.frame && !s.crs)
		else $error("frame held without signal");
	dv_fall_a: assert property (!ok && tick && s.rxclk |=> !O_RX_DV)
		else $error("dv held past falling clock");
	bad_ssd_a: assert property (s.wr && !s.wdata.dv |-> s.wdata.er
		&& s.wdata.d == NIB_BAD_SSD)
		else $error("bad delimiter word wrong");
	ssd_pair_a: assert property ($rose(s.frame) |-> ssd_nib_s ##1 ssd_nib_s)
		else $error("delimiter not two nibbles");
	rxd_fall_a: assert property ($changed(s.out) |-> $past(s.rxclk) && !s.rxclk)
		else $error("rxd moved off falling edge");
	lock_first_a: assert property (!s.locked && !I_DESCR_BYPASS |=> !$rose(s.frame))
		else $error("frame before lock");
endmodule // frp_pcs

`default_nettype wire

/* frp_mac_model.sv */
// Purpose: MAC model on the MII receive side
// Assumes: RX_CLK is a registered strobe of the system clock
// Notes: passes on only words with valid or error set
`timescale 1ns/1ns
`default_nettype none
module frp_mac_model
	import frp_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// MII receive side
	input wire logic i_rx_clk,
	input wire frp_mii_t i_mii,
	// captured words and timing fault
	output frp_mii_t o_word,
	output logic o_take,
	output logic o_skew
);
	logic clk_q;
	frp_mii_t mii_q;
	// capture on rising RX_CLK, flag data moving off the falling edge
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			clk_q <= 1'b0;
			mii_q <= '0;
			o_word <= '0;
			o_take <= 1'b0;
			o_skew <= 1'b0;
		end else begin
			clk_q <= i_rx_clk;
			mii_q <= i_mii;
			o_word <= i_mii;
			o_take <= i_rx_clk && !clk_q && (i_mii.dv || i_mii.er);
			o_skew <= o_skew || (i_mii != mii_q && !(clk_q && !i_rx_clk));
		end
	end
endmodule // frp_mac_model
`default_nettype wire

/* frp_pcs_tb.sv */
// Purpose: self-checking bench for the 100M coding block
// Assumes: descrambler bypassed except in the scrambled-line scenario
// Notes: recovered ticks stall once to fill the buffer
`timescale 1ns/1ns
`default_nettype none
module frp_pcs_tb
	import frp_pkg::*;
;
	localparam logic [4:0] CODES [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
		5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic rx_valid = 1'b0;
	logic rec_tick = 1'b0;
	logic ref_tick = 1'b0;
	logic rec_on = 1'b1;
	logic sig = 1'b0;
	logic link_fail = 1'b0;
	logic dec_en = 1'b1;
	frp_lvl_t rx_level = LVL_ZERO;
	frp_lvl_t lvl = LVL_ZERO;
	frp_lvl_t mlt3_q = LVL_ZERO;
	frp_lvl_t exp_lvl;
	frp_lvl_t tx_mlt3;
	logic tx_ready, tx_nrzi, sym_ready, rx_clk, rx_dv, rx_er, crs, take, skew;
	logic [3:0] rxd;
	frp_mii_t word;
	logic up = 1'b1;
	logic byp = 1'b1;
	logic [10:0] lfsr = 11'h2A5;
	logic nrzi_q = 1'b0;
	logic went_pos = 1'b0;
	logic full_seen = 1'b0;
	int miscompares = 0;
	int n_checks = 0;
	int gap = -1;
	logic [4:0] gq[$];
	logic [5:0] eq[$];
	logic [5:0] got[$];

	always #25 clk = ~clk;
	// ticks: recovered one every cycle when on, reference every other cycle
	always @(posedge clk) begin
		rec_tick <= rec_on;
		ref_tick <= !ref_tick;
	end

	frp_pcs uut (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_TX_GROUP(5'h0B), .I_TX_VALID(1'b1),
		.O_TX_READY(tx_ready), .O_TX_NRZI(tx_nrzi), .O_TX_MLT3(tx_mlt3),
		.I_RX_LEVEL(rx_level), .I_RX_VALID(rx_valid), .O_RX_SYM_READY(sym_ready),
		.I_REC_TICK(rec_tick), .I_REFERENCE_CLOCK_INPUT_TICK(ref_tick),
		.I_SIGNAL_PRESENT_FLAG(sig), .I_LINK_FAIL(link_fail), .I_MGMT_PORT_ADDRESS(5'h03),
		.I_DESCR_BYPASS(byp), .I_DECODE_ENABLE(dec_en), .I_MII_MODE(1'b1),
		.O_RX_CLK(rx_clk), .O_RXD(rxd), .O_RX_DV(rx_dv), .O_ERROR_OR_FIFTH_RX_BIT(rx_er),
		.O_CRS(crs));
	frp_mac_model mac (.i_clk(clk), .i_rst_n(rst_n), .i_rx_clk(rx_clk),
		.i_mii({rx_dv, rx_er, rxd}), .o_word(word), .o_take(take), .o_skew(skew));

	task automatic check(input string what, input logic [5:0] e, input logic [5:0] s);
		n_checks++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, e, s);
		end
	endtask

	// word capture, buffer-full watch and tx line monitor
	always @(posedge clk) begin
		if (take === 1'b1)
			got.push_back(word);
		if (sym_ready === 1'b0 && !rec_on)
			full_seen = 1'b1;
		if (rst_n) begin
			exp_lvl = mlt3_q;
			if (tx_nrzi !== nrzi_q)
				exp_lvl = (mlt3_q != LVL_ZERO) ? LVL_ZERO : (went_pos ? LVL_NEG : LVL_POS);
			check("tx level", 6'(exp_lvl), 6'(tx_mlt3));
			if (tx_mlt3 != LVL_ZERO)
				went_pos = (tx_mlt3 == LVL_POS);
			if (tx_ready === 1'b1 && gap >= 0)
				check("tx slot", 6'h04, 6'(gap));
			gap = (tx_ready === 1'b1) ? 0 : ((gap >= 0) ? gap + 1 : gap);
			nrzi_q = tx_nrzi;
			mlt3_q = tx_mlt3;
		end
	end

	// each one bit steps the MLT-3 level, a zero holds it
	task automatic send();
		logic b;
		foreach (gq[k])
			for (int i = 4; i >= 0; i--) begin
				b = gq[k][i];
				// scrambled line: same x11+x9+1 sequence as the transmitter
				if (!byp) begin
					b = b ^ lfsr[10] ^ lfsr[8];
					lfsr = {lfsr[9:0], lfsr[10] ^ lfsr[8]};
				end
				if (b && lvl != LVL_ZERO)
					lvl = LVL_ZERO;
				else if (b) begin
					lvl = up ? LVL_POS : LVL_NEG;
					up = !up;
				end
				rx_level <= lvl;
				rx_valid <= 1'b1;
				@(posedge clk);
				while (sym_ready !== 1'b1)
					@(posedge clk);
			end
		rx_valid <= 1'b0;
		@(posedge clk);
	endtask

	// words with valid and error both set compare those two bits only, their data is arbitrary
	task automatic expect_w();
		int n;
		n = 0;
		while (got.size() < eq.size() && n < 3000) begin
			@(posedge clk);
			n++;
		end
		repeat (40) @(posedge clk);
		check("word count", 6'(eq.size()), 6'(got.size()));
		foreach (eq[k])
			if (k < got.size())
				check("mii word", eq[k], got[k] & ((eq[k][5:4] == 2'b11) ? 6'h30 : 6'h3F));
		got = {};
	endtask

	task automatic start_frame();
		gq = {G_IDLE, G_IDLE, G_IDLE, G_IDLE, G_IDLE, G_IDLE, G_IDLE, G_IDLE, G_J, G_K};
		eq = {6'h25, 6'h25};
	endtask

	task automatic data(input logic [4:0] g, input logic [5:0] e);
		gq.push_back(g);
		eq.push_back(e);
	endtask

	// every data group, closed by T R
	task automatic t_good();
		start_frame();
		for (int v = 0; v < 16; v++)
			data(CODES[v], {2'b10, 4'(v)});
		gq = {gq, G_T, G_R};
		send();
		expect_w();
		check("carrier", 6'h00, {5'h00, crs});
	endtask

	// J followed by idle is a bad start
	task automatic t_bad_ssd();
		start_frame();
		gq[9] = G_IDLE;
		gq.push_back(G_IDLE);
		eq = {6'h1E};
		send();
		expect_w();
	endtask

	// invalid groups inside a frame, closed by two idles
	task automatic t_err();
		start_frame();
		data(CODES[3], 6'h23);
		data(5'h06, 6'h30);
		data(5'h19, 6'h30);
		data(CODES[7], 6'h27);
		gq = {gq, G_IDLE, G_IDLE};
		send();
		expect_w();
		check("carrier", 6'h00, {5'h00, crs});
	endtask

	// decode bypass puts the fifth bit on the error pin
	task automatic t_bypass();
		dec_en <= 1'b0;
		start_frame();
		data(5'h13, 6'h30);
		data(5'h04, 6'h24);
		gq = {gq, G_T, G_R};
		send();
		expect_w();
		dec_en <= 1'b1;
	endtask

	// link failure or lost signal drops valid mid-frame
	task automatic t_drop(input logic cut_sig);
		int n;
		start_frame();
		data(CODES[1], 6'h21);
		send();
		n = 0;
		while (rx_dv !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		link_fail <= !cut_sig;
		sig <= cut_sig ? 1'b0 : 1'b1;
		repeat (10) @(posedge clk);
		check("rx valid", 6'h00, {5'h00, rx_dv});
		link_fail <= 1'b0;
		sig <= 1'b1;
		repeat (40) @(posedge clk);
		got = {};
	endtask

	// stalled recovered ticks freeze RX_CLK, buffer fills, then drains in order
	task automatic t_fill();
		rec_on <= 1'b0;
		start_frame();
		for (int v = 0; v < 40; v++)
			data(CODES[v % 16], {2'b10, 4'(v % 16)});
		gq = {gq, G_T, G_R};
		fork
			send();
			begin
				repeat (400) @(posedge clk);
				rec_on <= 1'b1;
			end
		join
		expect_w();
		check("buffer full", 6'h01, {5'h00, full_seen});
		check("rx timing", 6'h00, {5'h00, skew});
	endtask

	// stale lock times out, short idle gives no frame, long idle relocks
	task automatic t_scr();
		byp <= 1'b0;
		repeat (850) @(posedge clk);
		gq = {G_IDLE, G_IDLE, G_J, G_K, CODES[1], G_T, G_R};
		eq = {};
		send();
		expect_w();
		start_frame();
		gq = {G_IDLE, G_IDLE, G_IDLE, G_IDLE, gq};
		for (int v = 0; v < 16; v++)
			data(CODES[v], {2'b10, 4'(v)});
		gq = {gq, G_T, G_R};
		send();
		expect_w();
	endtask

	task automatic results();
		if (miscompares == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		sig <= 1'b1;
		repeat (5) @(posedge clk);
		check("mii idle", 6'h00, {rx_dv, rx_er, rxd});
		t_good();
		t_bad_ssd();
		t_err();
		t_bypass();
		t_drop(1'b0);
		t_drop(1'b1);
		t_fill();
		t_scr();
		results();
	end
	// watchdog well beyond the expected few thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		results();
	end
endmodule // frp_pcs_tb
`default_nettype wire
